// [logic/mls_lane.sv]
// one high-speed lane: receive deserializer or transmit serializer with low-power pads
`timescale 1ns/10ps
module mls_lane
  import mls_pkg::*;
#(
  parameter int unsigned LANE_INDEX  = 0,          // position inside the group
  parameter int unsigned GROUP_INDEX = 0,          // receive group number
  parameter int unsigned FIFO_DEPTH  = MLS_FIFO_DEPTH,
  parameter logic [4:0]  DLY_INIT    = MLS_DLY_INIT
) (
  // clock, enable, reset
  input  wire logic        clk,
  input  wire logic        ce,
  input  wire logic        reset_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // high-speed pad side
  input  wire logic        hs_rx_bit,
  output logic             hs_tx_bit,
  output logic             highspeed_drive_en,
  output logic             highspeed_rx_buffer_en,
  output logic             highspeed_termination_en,
  // low-power pads, three signals each
  input  wire logic        lp_pos_pad_i,
  output logic             lp_pos_pad_o,
  output logic             lp_pos_pad_oe,
  input  wire logic        lp_neg_pad_i,
  output logic             lp_neg_pad_o,
  output logic             lp_neg_pad_oe,
  // low-power fabric side
  input  wire logic        lowpower_pos_drive,
  input  wire logic        lowpower_neg_drive,
  input  wire logic        lowpower_pos_drive_en,
  input  wire logic        lowpower_neg_drive_en,
  output logic             lowpower_pos_level_in,
  output logic             lowpower_neg_level_in,
  // clocks, forwarded and from pll
  input  wire logic        pll_parallel_tick,
  output logic             fwd_serial_clock,
  output logic             fwd_parallel_clock,
  output logic             core_parallel_clock,
  // receive data and queue
  output logic      [7:0]  hs_rx_word,
  output logic             hs_rx_word_valid,
  input  wire logic        queue_read_en,
  output logic             queue_empty,
  input  wire logic        rx_lane_clear,
  // transmit data
  input  wire logic [7:0]  hs_tx_word,
  input  wire logic        tx_lane_clear,
  // input delay control
  input  wire logic        delay_step_en,
  input  wire logic        delay_step_up,
  input  wire logic        delay_counter_clear
);

  // ********************************
  // declarations
  // ********************************
  localparam int unsigned LW = $clog2(FIFO_DEPTH);
  localparam logic [LW:0] FULL_LVL = (LW+1)'(FIFO_DEPTH);

  logic [MLS_CTL_W-1:0] ctrl_q, ctrl_d;       // software control
  logic                 ovf_q, ovf_d;         // sticky overflow
  logic [31:0]          rdat_q, rdat_d;       // bus read data
  logic                 ack_q, ack_d;         // bus answer
  logic [2:0]           div_q, div_d;         // fast-to-slow divider
  logic                 sclk_q, sclk_d;       // forwarded serial clock
  logic                 pclk_q, pclk_d;       // forwarded parallel clock
  logic                 cclk_q, cclk_d;       // core parallel clock
  logic [7:0]           rsh_q, rsh_d;         // deserializer shift
  logic [2:0]           rcnt_q, rcnt_d;       // bits gathered
  logic [7:0]           word_q, word_d;       // word to fabric
  logic                 wval_q, wval_d;       // word strobe
  logic [7:0]           tsh_q, tsh_d;         // serializer shift
  logic                 tbit_q, tbit_d;       // serial bit out
  logic [4:0]           dly_q, dly_d;         // input delay setting
  logic [LW-1:0]        wp_q, wp_d, rp_q, rp_d;
  logic [LW:0]          lvl_q, lvl_d;         // queue fill level
  logic [7:0]           mem [FIFO_DEPTH];     // queue storage
  logic                 push, pop, tick, tx_mode, fifo_on, bus_go;
  logic [5:0]           pads_q, pads_d;       // registered pad outputs
  logic                 hsen_q, hsen_d;       // high-speed driver enable copy
  logic                 empty_q, empty_d;     // queue empty flag, high after reset

  // ********************************
  // combinational next state
  // ********************************
  always_comb begin
    tx_mode = ctrl_q[MLS_CTL_TX];
    fifo_on = ctrl_q[MLS_CTL_FIFO] & ~tx_mode;
    bus_go  = wb_cyc_i & wb_stb_i & ~ack_q;
    // word boundary: own divider when receiving, pll when sending
    tick    = tx_mode ? pll_parallel_tick : (div_q == 3'h7);
    ctrl_d  = ctrl_q;
    ovf_d   = ovf_q;
    rdat_d  = rdat_q;
    ack_d   = bus_go;
    // bus access, single cycle answer, unmapped reads give zero
    if (bus_go && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == MLS_ADR_CTRL) begin
        ctrl_d = wb_dat_i[MLS_CTL_W-1:0];
      end
    end
    if (bus_go && !wb_we_i) begin
      unique case (wb_adr_i)
        MLS_ADR_CTRL:   rdat_d = {26'h0, ctrl_q};
        MLS_ADR_STATUS: rdat_d = {13'h0, (3'(lvl_q)), 3'h0, dly_q, 6'h0, ovf_q,
                                  (lvl_q == '0)};
        MLS_ADR_ID:     rdat_d = {19'h0, 5'(GROUP_INDEX), 5'h0, 3'(LANE_INDEX)};
        default:        rdat_d = 32'h0;
      endcase
    end
    // divider runs off the fast clock only in receive mode
    div_d  = tx_mode ? 3'h0 : div_q + 3'h1;
    sclk_d = tx_mode ? 1'b0 : ~sclk_q;
    pclk_d = tx_mode ? 1'b0 : div_d[2];
    cclk_d = tx_mode ? 1'b0 : div_d[2];
    // deserializer, buffer off feeds zeros; no alignment search here
    rsh_d  = {rsh_q[6:0], hs_rx_bit & ctrl_q[MLS_CTL_RXBUF]};
    rcnt_d = rcnt_q + 3'h1;
    wval_d = 1'b0;
    word_d = word_q;
    push   = 1'b0;
    if (!tx_mode && rcnt_q == 3'h7) begin
      push = fifo_on;
      if (!fifo_on) begin
        word_d = rsh_d;
        wval_d = 1'b1;
      end
    end
    // queue, fabric pops with read enable
    pop  = fifo_on & queue_read_en & (lvl_q != '0);
    wp_d = push && lvl_q != FULL_LVL ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    lvl_d = lvl_q + (LW+1)'(push && lvl_q != FULL_LVL) - (LW+1)'(pop);
    if (pop) begin
      word_d = mem[rp_q];
      wval_d = 1'b1;
    end
    // overflow set wins over software clear
    if (bus_go && wb_we_i && wb_sel_i[0] && wb_adr_i == MLS_ADR_STATUS &&
        wb_dat_i[MLS_ST_OVF]) begin
      ovf_d = 1'b0;
    end
    if (push && lvl_q == FULL_LVL) begin
      ovf_d = 1'b1;
    end
    if (rx_lane_clear) begin
      rsh_d  = 8'h0;
      rcnt_d = 3'h0;
      wp_d   = '0;
      rp_d   = '0;
      lvl_d  = '0;
      wval_d = 1'b0;
    end
    // serializer, word taken at each slow tick, msb first
    tsh_d  = tick ? hs_tx_word : {tsh_q[6:0], 1'b0};
    tbit_d = tx_mode & ctrl_q[MLS_CTL_HSDRV] & tsh_q[7];
    if (tx_lane_clear) begin
      tsh_d  = 8'h0;
      tbit_d = 1'b0;
    end
    // input delay counter, saturates at its ends
    dly_d = dly_q;
    if (delay_counter_clear) begin
      dly_d = DLY_INIT;
    end else if (tick && delay_step_en) begin
      if (delay_step_up && dly_q != 5'h1f) begin
        dly_d = dly_q + 5'h1;
      end else if (!delay_step_up && dly_q != 5'h0) begin
        dly_d = dly_q - 5'h1;
      end
    end
    // low-power pads: levels and drives straight through, no serdes involved
    pads_d[0] = lowpower_pos_drive;
    pads_d[1] = lowpower_neg_drive;
    // receive lanes drive pads only when reversible
    pads_d[2] = lowpower_pos_drive_en & (tx_mode | ctrl_q[MLS_CTL_REV]);
    pads_d[3] = lowpower_neg_drive_en & (tx_mode | ctrl_q[MLS_CTL_REV]);
    pads_d[4] = lp_pos_pad_i;
    pads_d[5] = lp_neg_pad_i;
    // enable and empty flags are registered copies so every port leaves a flop;
    // taking them from the next values keeps them in step with ctrl_q and lvl_q
    hsen_d  = ctrl_d[MLS_CTL_HSDRV] & ctrl_d[MLS_CTL_TX];
    empty_d = (lvl_d == '0);
  end

  // ********************************
  // state registers
  // ********************************
  // every flop holds while ce is low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q <= MLS_CTRL_RESET;
      ovf_q  <= 1'b0;
      rdat_q <= 32'h0;
      ack_q  <= 1'b0;
      div_q  <= 3'h0;
      sclk_q <= 1'b0;
      pclk_q <= 1'b0;
      cclk_q <= 1'b0;
      rsh_q  <= 8'h0;
      rcnt_q <= 3'h0;
      word_q <= 8'h0;
      wval_q <= 1'b0;
      tsh_q  <= 8'h0;
      tbit_q <= 1'b0;
      dly_q  <= DLY_INIT;
      wp_q   <= '0;
      rp_q   <= '0;
      lvl_q  <= '0;
      pads_q <= 6'h0;
      // driver off and queue empty straight out of reset
      hsen_q  <= 1'b0;
      empty_q <= 1'b1;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      ovf_q  <= ovf_d;
      rdat_q <= rdat_d;
      ack_q  <= ack_d;
      div_q  <= div_d;
      sclk_q <= sclk_d;
      pclk_q <= pclk_d;
      cclk_q <= cclk_d;
      rsh_q  <= rsh_d;
      rcnt_q <= rcnt_d;
      word_q <= word_d;
      wval_q <= wval_d;
      tsh_q  <= tsh_d;
      tbit_q <= tbit_d;
      dly_q  <= dly_d;
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      lvl_q  <= lvl_d;
      pads_q <= pads_d;
      hsen_q  <= hsen_d;
      empty_q <= empty_d;
    end
  end

  // queue storage, written only on a push that fits
  always_ff @(posedge clk) begin
    if (ce && push && lvl_q != FULL_LVL && !rx_lane_clear) begin
      mem[wp_q] <= rsh_d;
    end
  end

  // ********************************
  // outputs, all from flops
  // ********************************
  always_comb begin
    wb_dat_o                 = rdat_q;
    wb_ack_o                 = ack_q;
    hs_tx_bit                = tbit_q;
    highspeed_drive_en       = hsen_q;
    highspeed_rx_buffer_en   = ctrl_q[MLS_CTL_RXBUF];
    highspeed_termination_en = ctrl_q[MLS_CTL_TERM];
    lp_pos_pad_o             = pads_q[0];
    lp_neg_pad_o             = pads_q[1];
    lp_pos_pad_oe            = pads_q[2];
    lp_neg_pad_oe            = pads_q[3];
    lowpower_pos_level_in    = pads_q[4];
    lowpower_neg_level_in    = pads_q[5];
    fwd_serial_clock         = sclk_q;
    fwd_parallel_clock       = pclk_q;
    core_parallel_clock      = cclk_q;
    hs_rx_word               = word_q;
    hs_rx_word_valid         = wval_q;
    queue_empty              = empty_q;
  end

endmodule // mls_lane

// [include/mls_pkg.sv]
// constants shared by the lane serdes logic
package mls_pkg;
  // ********************************
  // lane structure
  // ********************************
  localparam int unsigned MLS_SER_FACTOR  = 8;   // bits per parallel word
  localparam int unsigned MLS_MAX_LANES   = 8;   // data lanes per group
  localparam int unsigned MLS_MAX_GROUPS  = 18;  // receive groups per device
  localparam int unsigned MLS_DLY_BITS    = 5;   // delay counter width
  localparam logic [4:0]  MLS_DLY_INIT    = 5'h10; // delay counter start point
  localparam int unsigned MLS_FIFO_DEPTH  = 4;   // receive queue words

  // ********************************
  // register offsets (byte addresses)
  // ********************************
  localparam logic [7:0] MLS_ADR_CTRL   = 8'h00;
  localparam logic [7:0] MLS_ADR_STATUS = 8'h04;
  localparam logic [7:0] MLS_ADR_ID     = 8'h08;

  // ********************************
  // control fields
  // ********************************
  localparam int unsigned MLS_CTL_TX      = 0;  // 1: transmit lane, 0: receive
  localparam int unsigned MLS_CTL_FIFO    = 1;  // receive queue in use
  localparam int unsigned MLS_CTL_RXBUF   = 2;  // high-speed input buffer on
  localparam int unsigned MLS_CTL_TERM    = 3;  // high-speed termination on
  localparam int unsigned MLS_CTL_HSDRV   = 4;  // high-speed driver on
  localparam int unsigned MLS_CTL_REV     = 5;  // reversible data lane
  localparam int unsigned MLS_CTL_W       = 6;
  localparam logic [5:0]  MLS_CTRL_RESET  = 6'h00;

  // ********************************
  // status and id fields
  // ********************************
  localparam int unsigned MLS_ST_EMPTY    = 0;  // queue empty
  localparam int unsigned MLS_ST_OVF      = 1;  // queue overflow, write 1 to clear
  localparam int unsigned MLS_ST_DLY_LSB  = 8;  // delay counter value
  localparam int unsigned MLS_ST_LVL_LSB  = 16; // queue fill level
  localparam int unsigned MLS_ID_GRP_LSB  = 8;  // group index position
endpackage : mls_pkg

// [dv/mls_lane_sva.sv]
// checker for the lane serdes ports
`timescale 1ns/10ps
module mls_lane_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        ce,
  input wire logic        reset_n,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // lane
  input wire logic        hs_tx_bit,
  input wire logic        highspeed_drive_en,
  input wire logic        lp_pos_pad_i,
  input wire logic        lp_neg_pad_i,
  input wire logic        lp_pos_pad_o,
  input wire logic        lp_pos_pad_oe,
  input wire logic        lowpower_pos_drive,
  input wire logic        lowpower_pos_drive_en,
  input wire logic        lowpower_pos_level_in,
  input wire logic        lowpower_neg_level_in,
  input wire logic        fwd_serial_clock,
  input wire logic        fwd_parallel_clock,
  input wire logic        core_parallel_clock
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a request, then a one-cycle answer
  sequence wb_req; wb_cyc_i && wb_stb_i && !wb_ack_o && ce; endsequence
  sequence wb_ans; wb_ack_o ##1 !wb_ack_o; endsequence
  bus_answer_a: assert property (wb_req |=> wb_ans)
    else $error("bus request not answered in one cycle");
  unmapped_read_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h0b
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  // a low enable freezes every flop, so each step check needs ce on its first edge
  serial_toggle_a: assert property (fwd_serial_clock && ce |=> !fwd_serial_clock)
    else $error("serial clock did not toggle");
  clock_match_a: assert property (core_parallel_clock == fwd_parallel_clock)
    else $error("core and forwarded parallel clocks differ");
  // an edge still in reset clears the pad copies instead of passing levels
  lp_level_a: assert property (reset_n && ce |=>
    lowpower_pos_level_in == $past(lp_pos_pad_i) && lowpower_neg_level_in == $past(lp_neg_pad_i))
    else $error("pad level not passed");
  lp_drive_a: assert property (reset_n && ce |=>
    lp_pos_pad_o == $past(lowpower_pos_drive)) else $error("pad drive not passed");
  lp_gate_a: assert property (ce && !lowpower_pos_drive_en |=> !lp_pos_pad_oe)
    else $error("pad driven without enable");
  hs_gate_a: assert property (!highspeed_drive_en && ce |=> !hs_tx_bit)
    else $error("serial output active while disabled");
endmodule // mls_lane_chk

bind mls_lane mls_lane_chk i_mls_lane_chk (.clk, .ce, .reset_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .hs_tx_bit, .highspeed_drive_en, .lp_pos_pad_i,
  .lp_neg_pad_i, .lp_pos_pad_o, .lp_pos_pad_oe, .lowpower_pos_drive, .lowpower_pos_drive_en,
  .lowpower_pos_level_in, .lowpower_neg_level_in, .fwd_serial_clock, .fwd_parallel_clock,
  .core_parallel_clock);

// [dv/mls_far_end.sv]
// far-end transmitter model: serial bits msb first and low-power pad levels
`timescale 1ns/10ps
module mls_far_end (
  // clock and command
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] byte_i,
  input  wire logic [1:0] lp_lvl,
  // pad side
  output logic            hs_bit = 1'h0,
  output logic            pos_pad,
  output logic            neg_pad
);
  logic [7:0] sr_q  = 8'h00; // bits still to send
  logic [3:0] cnt_q = 4'h0;  // bits left in the frame
  // low-power levels need no clock at all
  assign pos_pad = lp_lvl[1];
  assign neg_pad = lp_lvl[0];
  // raw bits, no sync pattern: the receiving fabric aligns
  always @(posedge clk) begin
    if (go) begin
      hs_bit <= byte_i[7];
      sr_q   <= {byte_i[6:0], 1'h0};
      cnt_q  <= 4'h7;
    end else if (cnt_q != 4'h0) begin
      hs_bit <= sr_q[7];
      sr_q   <= {sr_q[6:0], 1'h0};
      cnt_q  <= cnt_q - 4'h1;
    end else begin
      hs_bit <= ~hs_bit; // idle line toggles so stale data never matches
    end
  end
endmodule // mls_far_end

// [dv/mls_lane_tb.sv]
// self-checking bench for the lane serdes
`timescale 1ns/10ps
module mls_lane_tb;
  import mls_pkg::*;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
  logic clk = 1'h0, ce = 1'h1, reset_n = 1'h0, go = 1'h0, pll_parallel_tick = 1'h0;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00, hs_rx_word, hs_tx_word = 8'hc3, cap;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic hs_rx_bit, hs_tx_bit, highspeed_drive_en, highspeed_rx_buffer_en;
  logic highspeed_termination_en, lp_pos_pad_i, lp_pos_pad_o, lp_pos_pad_oe;
  logic lp_neg_pad_i, lp_neg_pad_o, lp_neg_pad_oe, lowpower_pos_level_in, lowpower_neg_level_in;
  logic lowpower_pos_drive = 1'h0, lowpower_neg_drive = 1'h0;
  logic lowpower_pos_drive_en = 1'h0, lowpower_neg_drive_en = 1'h0;
  logic fwd_serial_clock, fwd_parallel_clock, core_parallel_clock, hs_rx_word_valid, queue_empty;
  logic queue_read_en = 1'h0, rx_lane_clear = 1'h0, tx_lane_clear = 1'h0;
  logic delay_step_en = 1'h0, delay_step_up = 1'h0, delay_counter_clear = 1'h0;
  logic [1:0] lp_lvl = 2'h2;
  int err_total = 0, total_checks = 0, cyc_cnt = 0;
  // ****************
  // harness
  // ****************
  always #12.5 clk = ~clk;
  mls_lane #(.LANE_INDEX(3), .GROUP_INDEX(5)) i_mls_lane (.clk, .ce, .reset_n, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .hs_rx_bit,
    .hs_tx_bit, .highspeed_drive_en, .highspeed_rx_buffer_en, .highspeed_termination_en,
    .lp_pos_pad_i, .lp_pos_pad_o, .lp_pos_pad_oe, .lp_neg_pad_i, .lp_neg_pad_o, .lp_neg_pad_oe,
    .lowpower_pos_drive, .lowpower_neg_drive, .lowpower_pos_drive_en, .lowpower_neg_drive_en,
    .lowpower_pos_level_in, .lowpower_neg_level_in, .pll_parallel_tick, .fwd_serial_clock,
    .fwd_parallel_clock, .core_parallel_clock, .hs_rx_word, .hs_rx_word_valid, .queue_read_en,
    .queue_empty, .rx_lane_clear, .hs_tx_word, .tx_lane_clear, .delay_step_en, .delay_step_up,
    .delay_counter_clear);
  // far end runs on the lane's own clock, as a lane of its group would
  mls_far_end i_mls_far_end (.clk, .go, .byte_i(8'h96), .lp_lvl, .hs_bit(hs_rx_bit),
    .pos_pad(lp_pos_pad_i), .neg_pad(lp_neg_pad_i));
  // one classic cycle; holds everything until ack is sampled
  task automatic wb_go(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    wb_go(1'h0, MLS_ADR_STATUS, 32'h0);
    `CHK(rd, 32'h0000_1001)
    wb_go(1'h0, MLS_ADR_ID, 32'h0);
    `CHK(rd, 32'h0000_0503)
    wb_go(1'h0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 2; i++) begin
      wb_go(1'h1, MLS_ADR_CTRL, 32'h8 >> i);
      `CHK(highspeed_rx_buffer_en, i == 1)
      `CHK(highspeed_termination_en, i == 0)
    end
    // align one word to the deserializer's own word boundary
    do @(posedge clk); while (hs_rx_word_valid !== 1'h1);
    `CHK(fwd_parallel_clock, 1'h0)
    repeat (6) @(posedge clk);
    `CHK({fwd_parallel_clock, core_parallel_clock}, 2'h3)
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    repeat (9) @(posedge clk);
    `CHK({hs_rx_word_valid, hs_rx_word}, 9'h196)
    // a low enable freezes the divider and the forwarded clocks with it
    ce <= 1'h0;
    @(posedge clk);
    cap = {6'h0, fwd_serial_clock, fwd_parallel_clock};
    repeat (5) @(posedge clk);
    `CHK({fwd_serial_clock, fwd_parallel_clock}, cap[1:0])
    ce <= 1'h1;
    // queue fills past its depth, then pops and clears
    wb_go(1'h1, MLS_ADR_CTRL, 32'h6);
    repeat (48) @(posedge clk);
    `CHK(queue_empty, 1'h0)
    wb_go(1'h0, MLS_ADR_STATUS, 32'h0);
    `CHK({rd[18:16], rd[1]}, 4'h9)
    queue_read_en <= 1'h1;
    @(posedge clk);
    queue_read_en <= 1'h0;
    @(posedge clk);
    `CHK(hs_rx_word_valid, 1'h1)
    rx_lane_clear <= 1'h1;
    @(posedge clk);
    rx_lane_clear <= 1'h0;
    @(posedge clk);
    `CHK(queue_empty, 1'h1)
    // delay saturates high, then five ticks down, then clear
    wb_go(1'h1, MLS_ADR_CTRL, 32'h0);
    delay_step_en <= 1'h1;
    delay_step_up <= 1'h1;
    repeat (300) @(posedge clk);
    delay_step_up <= 1'h0;
    repeat (40) @(posedge clk);
    delay_step_en <= 1'h0;
    wb_go(1'h0, MLS_ADR_STATUS, 32'h0);
    `CHK(rd[12:8], 5'h1a)
    delay_counter_clear <= 1'h1;
    @(posedge clk);
    delay_counter_clear <= 1'h0;
    wb_go(1'h0, MLS_ADR_STATUS, 32'h0);
    `CHK(rd[12:8], MLS_DLY_INIT)
    // transmit one word msb first, with pad drives
    wb_go(1'h1, MLS_ADR_CTRL, 32'h11);
    `CHK({highspeed_drive_en, fwd_serial_clock, core_parallel_clock}, 3'h4)
    lowpower_pos_drive <= 1'h1;
    lowpower_neg_drive <= 1'h1;
    lowpower_pos_drive_en <= 1'h1;
    lp_lvl <= 2'h1;
    // second pass clears the serializer just after the load: nothing may leave
    for (int k = 0; k < 2; k++) begin
      pll_parallel_tick <= 1'h1;
      @(posedge clk);
      pll_parallel_tick <= 1'h0;
      tx_lane_clear <= k[0];
      repeat (2) @(posedge clk);
      tx_lane_clear <= 1'h0;
      for (int i = 7; i >= 0; i--) begin
        cap[i] = hs_tx_bit;
        @(posedge clk);
      end
      `CHK(cap, k[0] ? 8'h00 : 8'hc3)
    end
    `CHK({lp_pos_pad_o, lp_neg_pad_o, lp_pos_pad_oe, lp_neg_pad_oe}, 4'he)
    `CHK({lowpower_pos_level_in, lowpower_neg_level_in}, 2'h1)
    for (int i = 0; i < 2; i++) begin
      wb_go(1'h1, MLS_ADR_CTRL, 32'h20 * i);
      @(posedge clk);
      `CHK(lp_pos_pad_oe, i == 1)
    end
    close_out();
  end
endmodule // mls_lane_tb
